// [codec_pkg.sv]
// Shared constants for the codec count/status register bank and its host controller
package codec_pkg;
   // Indexed register offsets
   localparam logic [3:0] IDX_PIN_CTRL   = 4'ha;
   localparam logic [3:0] IDX_FAULT_STAT = 4'hb;
   localparam logic [3:0] IDX_REVISION   = 4'hc;
   localparam logic [3:0] IDX_MIX_CTRL   = 4'hd;
   localparam logic [3:0] IDX_COUNT_HIGH = 4'he;
   localparam logic [3:0] IDX_COUNT_LOW  = 4'hf;
   // Field positions
   localparam int PIN_GATE_BIT   = 1;
   localparam int PIN_EXT_LO     = 6;
   localparam int MIX_ON_BIT     = 0;
   localparam int MIX_ATT_LO     = 2;
   localparam int STAT_INT_BIT   = 0;
   localparam int STAT_FAULT_BIT = 4;
   localparam logic [7:0] PIN_WRITABLE_MASK = 8'hc2;
   // Reset values
   localparam logic [7:0] PIN_CTRL_RST  = 8'h00;
   localparam logic [7:0] MIX_CTRL_RST  = 8'h00;
   localparam logic [7:0] COUNT_RST     = 8'h00;
   localparam logic [3:0] REVISION_DEF  = 4'h3;
   // Sample periods that calib_busy stays high after leaving mode change
   localparam logic [7:0] CALIB_TAIL_PERIODS = 8'h80;
   // Midscale for twos-complement samples
   localparam logic [15:0] MIDSCALE = 16'h0000;
   // Attenuation mantissas, Q8: 0, -1.5, -3, -4.5 dB
   localparam logic [8:0] ATT_M0 = 9'h100;
   localparam logic [8:0] ATT_M1 = 9'h0d7;
   localparam logic [8:0] ATT_M2 = 9'h0b5;
   localparam logic [8:0] ATT_M3 = 9'h099;
   localparam int ATT_FRAC_BITS  = 8;
   // Host controller Avalon byte offsets
   localparam logic [4:0] HOFS_IDX_WRITE = 5'h00;
   localparam logic [4:0] HOFS_IDX_READ  = 5'h04;
   localparam logic [4:0] HOFS_STATUS    = 5'h08;
   localparam logic [4:0] HOFS_PLAY      = 5'h0c;
   localparam logic [4:0] HOFS_CAPTURE   = 5'h10;
   localparam logic [4:0] HOFS_COUNT     = 5'h14;
   localparam logic [4:0] HOFS_PINS      = 5'h18;
endpackage

// [codec_link_if.sv]
// Link between the codec register bank and the host controller
`timescale 1ns/1ps
interface codec_link_if;
   logic [3:0]  index_select;
   logic        status_sel;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        play_wr;
   logic [15:0] play_data;
   logic        cap_rd;
   logic [15:0] cap_data;
   logic        play_request_pin;
   logic        cap_request_pin;
   logic        irq_pin;

   modport device (
      input  index_select, status_sel, reg_wr, reg_rd, reg_wdata, play_wr, play_data, cap_rd,
      output reg_rdata, cap_data, play_request_pin, cap_request_pin, irq_pin
   );
   modport host (
      output index_select, status_sel, reg_wr, reg_rd, reg_wdata, play_wr, play_data, cap_rd,
      input  reg_rdata, cap_data, play_request_pin, cap_request_pin, irq_pin
   );
endinterface

// [mix_atten.sv]
// Capture-to-playback mix attenuator, 1.5 dB per code step
`timescale 1ns/1ps
module mix_atten #(
   parameter int W = 16
) (
   input  wire logic signed [W-1:0] sample_in,
   input  wire logic [5:0]          code,
   output logic signed [W-1:0]      sample_out
);
   logic [8:0]              mant;
   logic signed [W+9:0]     prod;
   logic signed [W+9:0]     shifted;

   // Two low bits pick the fractional step, the upper four a 6 dB shift
   always_comb begin
      case (code[1:0])
         2'h0:    mant = codec_pkg::ATT_M0;
         2'h1:    mant = codec_pkg::ATT_M1;
         2'h2:    mant = codec_pkg::ATT_M2;
         default: mant = codec_pkg::ATT_M3;
      endcase
      prod       = sample_in * $signed({1'b0, mant});
      shifted    = prod >>> (codec_pkg::ATT_FRAC_BITS + int'(code[5:2]));
      sample_out = shifted[W-1:0];
   end
endmodule

// [codec_device.sv]
// Codec register bank: pin control, fault status, revision, mix and sample counter
//
// Behaviour
// - ext_ctrl_pins follow their control bits
// - irq_pin_gate gates counter interrupt onto pin
// - range levels per channel updated each sample
// - request_active_flag is OR of request pins
// - calib_busy during calibration or 128 periods after mode change ends
// - playback underrun flags and sends midscale
// - capture overrun flags, keeps old, drops new
// - any_sample_fault equals overrun OR underrun
// - read-only revision field, writes ignored
// - mix_on adds attenuated capture into playback
// - overrun mixes held sample, underrun mixes zero
// - mix attenuation 1.5 dB per step
// - low byte first, high write loads counter
// - count down to zero, then interrupt and reload
// - decrement only when enabled and not blocked
// - flag sets regardless of gate; pin follows flag while the gate bit is set
// - status write clears the interrupt flag
// - base bytes read back, current count hidden
// - host serves each sample within one period
// - PIO and DMA per direction independently
// - status, base bytes, mix bits reset zero
// - host writes zeros to reserved pin bits
`timescale 1ns/1ps
module codec_device #(
   parameter int         W        = 16,
   parameter logic [3:0] REVISION = codec_pkg::REVISION_DEF // Arbitrary value
) (
   input  wire logic          sys_clk,
   input  wire logic          nrst,
   codec_link_if.device       link,
   input  wire logic          sample_tick,
   input  wire logic          playback_on,
   input  wire logic          capture_on,
   input  wire logic          play_prog_io,
   input  wire logic          cap_prog_io,
   input  wire logic          request_block_bit,
   input  wire logic          mode_change_state,
   input  wire logic          calib_run,
   input  wire logic [1:0]    left_level,
   input  wire logic [1:0]    right_level,
   input  wire logic [W-1:0]  adc_sample,
   output logic [1:0]         ext_ctrl_pins,
   output logic [W-1:0]       dac_sample
);
   logic [7:0]   pin_ctrl_r, mix_ctrl_r, base_low_r, base_high_r, calib_cnt_r, rdata_r;
   logic [15:0]  cur_count_r;
   logic         int_flag_r, int_flag_nxt, underflow, count_en, irq_r, wr_idx, mc_prev_r;
   logic [1:0]   left_range_level, right_range_level;
   logic         playback_underrun, capture_overrun, any_sample_fault, request_active_flag, calib_busy;
   logic [W-1:0] play_buf_r, cap_buf_r, dac_r;
   logic         play_full_r, cap_full_r, play_req_r, cap_req_r;
   logic signed [W-1:0] mix_src, mix_att, play_src;
   logic signed [W:0]   mix_sum;

   assign wr_idx = link.reg_wr && !link.status_sel;

   // Software-written control bytes; reserved pin bits never store
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_ctrl_r <= codec_pkg::PIN_CTRL_RST;
         mix_ctrl_r <= codec_pkg::MIX_CTRL_RST;
      end else if (wr_idx) begin
         if (link.index_select == codec_pkg::IDX_PIN_CTRL)
            pin_ctrl_r <= link.reg_wdata & codec_pkg::PIN_WRITABLE_MASK;
         if (link.index_select == codec_pkg::IDX_MIX_CTRL)
            mix_ctrl_r <= {link.reg_wdata[7:2], 1'b0, link.reg_wdata[0]};
      end
   end

   // Base count bytes; the high byte write commits both to the counter
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         base_low_r  <= codec_pkg::COUNT_RST;
         base_high_r <= codec_pkg::COUNT_RST;
      end else if (wr_idx) begin
         if (link.index_select == codec_pkg::IDX_COUNT_LOW)
            base_low_r <= link.reg_wdata;
         if (link.index_select == codec_pkg::IDX_COUNT_HIGH)
            base_high_r <= link.reg_wdata;
      end
   end

   // Counter runs only when a direction is on and not blocked by a pending flag
   assign count_en  = sample_tick && (playback_on || capture_on)
                      && (!request_block_bit || !int_flag_r);
   assign underflow = count_en && (cur_count_r == 16'h0000);

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cur_count_r <= 16'h0000;
      end else if (wr_idx && link.index_select == codec_pkg::IDX_COUNT_HIGH) begin
         cur_count_r <= {link.reg_wdata, base_low_r};
      end else if (underflow) begin
         cur_count_r <= {base_high_r, base_low_r};
      end else if (count_en) begin
         cur_count_r <= cur_count_r - 16'h0001;
      end
   end

   // Underflow sets the flag even with the pin gated; set beats a clearing write
   always_comb begin
      int_flag_nxt = int_flag_r;
      if (link.reg_wr && link.status_sel)
         int_flag_nxt = 1'b0;
      if (underflow)
         int_flag_nxt = 1'b1;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         int_flag_r <= 1'b0;
         irq_r      <= 1'b0;
      end else begin
         int_flag_r <= int_flag_nxt;
         irq_r      <= int_flag_nxt && pin_ctrl_r[codec_pkg::PIN_GATE_BIT];
      end
   end

   // Range levels latched once per sample
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         left_range_level  <= 2'h0;
         right_range_level <= 2'h0;
      end else if (sample_tick) begin
         left_range_level  <= left_level;
         right_range_level <= right_level;
      end
   end

   // Playback single-sample buffer; a host write wins over the tick that drains it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         play_buf_r        <= codec_pkg::MIDSCALE;
         play_full_r       <= 1'b0;
         playback_underrun <= 1'b0;
         play_req_r        <= 1'b0;
      end else begin
         if (sample_tick)
            playback_underrun <= playback_on && !play_full_r;
         if (link.play_wr) begin
            play_buf_r  <= link.play_data;
            play_full_r <= 1'b1;
            play_req_r  <= 1'b0;
         end else if (sample_tick) begin
            play_full_r <= 1'b0;
            play_req_r  <= playback_on && !play_prog_io;
         end
      end
   end

   // Capture single-sample buffer; an unread sample is kept and the new one dropped
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         cap_buf_r       <= codec_pkg::MIDSCALE;
         cap_full_r      <= 1'b0;
         capture_overrun <= 1'b0;
         cap_req_r       <= 1'b0;
      end else begin
         if (sample_tick)
            capture_overrun <= capture_on && cap_full_r && !link.cap_rd;
         if (sample_tick && capture_on && (!cap_full_r || link.cap_rd)) begin
            cap_buf_r  <= adc_sample;
            cap_full_r <= 1'b1;
            cap_req_r  <= !cap_prog_io;
         end else if (link.cap_rd) begin
            cap_full_r <= 1'b0;
            cap_req_r  <= 1'b0;
         end
      end
   end

   // Mix path: overrun reuses the held sample, underrun plays midscale
   always_comb begin
      mix_src = (capture_on && cap_full_r && !link.cap_rd) ? signed'(cap_buf_r)
                                                           : signed'(adc_sample);
      if (playback_on && !play_full_r)
         play_src = signed'(codec_pkg::MIDSCALE);
      else if (playback_on)
         play_src = signed'(play_buf_r);
      else
         play_src = signed'(codec_pkg::MIDSCALE);
      if (mix_ctrl_r[codec_pkg::MIX_ON_BIT])
         mix_sum = {play_src[W-1], play_src} + {mix_att[W-1], mix_att};
      else
         mix_sum = {play_src[W-1], play_src};
   end

   mix_atten #(
      .W(W)
   ) u_atten (
      .sample_in (mix_src),
      .code      (mix_ctrl_r[7:codec_pkg::MIX_ATT_LO]),
      .sample_out(mix_att)
   );

   // Converter output updates per sample, saturated so the mix cannot wrap
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         dac_r <= codec_pkg::MIDSCALE;
      else if (sample_tick) begin
         if (mix_sum[W] != mix_sum[W-1])
            dac_r <= mix_sum[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
         else
            dac_r <= mix_sum[W-1:0];
      end
   end

   // Calibration tail counted in sample periods after mode change ends
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         mc_prev_r   <= 1'b0;
         calib_cnt_r <= 8'h00;
      end else begin
         mc_prev_r <= mode_change_state;
         if (mc_prev_r && !mode_change_state)
            calib_cnt_r <= codec_pkg::CALIB_TAIL_PERIODS;
         else if (sample_tick && calib_cnt_r != 8'h00)
            calib_cnt_r <= calib_cnt_r - 8'h01;
      end
   end

   assign calib_busy          = calib_run || (calib_cnt_r != 8'h00);
   assign request_active_flag = play_req_r || cap_req_r;
   assign any_sample_fault    = capture_overrun || playback_underrun;

   // Read data registered one cycle after the read strobe
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)
         rdata_r <= 8'h00;
      else if (link.reg_rd) begin
         if (link.status_sel)
            rdata_r <= 8'(({7'h00, int_flag_r} << codec_pkg::STAT_INT_BIT)
                        | ({7'h00, any_sample_fault} << codec_pkg::STAT_FAULT_BIT));
         else begin
            case (link.index_select)
               codec_pkg::IDX_PIN_CTRL:   rdata_r <= pin_ctrl_r;
               codec_pkg::IDX_FAULT_STAT: rdata_r <= {capture_overrun, playback_underrun, calib_busy,
                                                      request_active_flag, right_range_level,
                                                      left_range_level};
               codec_pkg::IDX_REVISION:   rdata_r <= {4'h0, REVISION};
               codec_pkg::IDX_MIX_CTRL:   rdata_r <= mix_ctrl_r;
               codec_pkg::IDX_COUNT_HIGH: rdata_r <= base_high_r;
               codec_pkg::IDX_COUNT_LOW:  rdata_r <= base_low_r;
               default:                   rdata_r <= 8'h00;
            endcase
         end
      end
   end

   assign link.reg_rdata        = rdata_r;
   assign link.cap_data         = cap_buf_r;
   assign link.play_request_pin = play_req_r;
   assign link.cap_request_pin  = cap_req_r;
   assign link.irq_pin          = irq_r;
   assign ext_ctrl_pins         = pin_ctrl_r[codec_pkg::PIN_EXT_LO +: 2];
   assign dac_sample            = dac_r;
endmodule

// [codec_host.sv]
// Host controller: Avalon-MM slave that drives the codec link
`timescale 1ns/1ps
module codec_host (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   codec_link_if.host       link
);
   typedef enum {ST_IDLE, ST_LINK, ST_WAIT, ST_DONE} host_state_e;

   host_state_e state_r;
   logic [3:0]  idx_r;
   logic        ssel_r;
   logic        wr_r;
   logic        rd_r;
   logic [7:0]  wdata_r;
   logic        pwr_r;
   logic [15:0] pdata_r;
   logic        crd_r;
   logic        high_pend_r;
   logic [7:0]  high_byte_r;
   logic        grab_reg_r;
   logic [7:0]  last_rd_r;
   logic [31:0] rdata_r;
   logic        wait_r;

   // Request sequencer; waitrequest drops for exactly one cycle per access
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         idx_r <= 4'h0;
         ssel_r <= 1'b0;
         wr_r <= 1'b0;
         rd_r <= 1'b0;
         wdata_r <= 8'h00;
         pwr_r <= 1'b0;
         pdata_r <= 16'h0000;
         crd_r <= 1'b0;
         high_pend_r <= 1'b0;
         high_byte_r <= 8'h00;
         grab_reg_r <= 1'b0;
         last_rd_r <= 8'h00;
         rdata_r <= 32'h0000_0000;
         wait_r <= 1'b1;
      end else begin
         case (state_r)
            ST_IDLE: begin
               grab_reg_r <= 1'b0;
               rdata_r <= 32'h0000_0000;
               if (avs_write) begin
                  state_r <= ST_LINK;
                  ssel_r <= 1'b0;
                  case (avs_address)
                     codec_pkg::HOFS_IDX_WRITE: begin
                        idx_r <= avs_writedata[11:8];
                        wdata_r <= (avs_writedata[11:8] == codec_pkg::IDX_PIN_CTRL)
                                   ? (avs_writedata[7:0] & codec_pkg::PIN_WRITABLE_MASK)
                                   : avs_writedata[7:0];
                        wr_r <= 1'b1;
                     end
                     codec_pkg::HOFS_IDX_READ: begin
                        idx_r <= avs_writedata[3:0];
                        rd_r <= 1'b1;
                        grab_reg_r <= 1'b1;
                     end
                     codec_pkg::HOFS_STATUS: begin
                        ssel_r <= 1'b1;
                        wr_r <= 1'b1;
                     end
                     codec_pkg::HOFS_PLAY: begin
                        pdata_r <= avs_writedata[15:0];
                        pwr_r <= 1'b1;
                     end
                     codec_pkg::HOFS_COUNT: begin
                        idx_r <= codec_pkg::IDX_COUNT_LOW;
                        wdata_r <= avs_writedata[7:0];
                        high_byte_r <= avs_writedata[15:8];
                        high_pend_r <= 1'b1;
                        wr_r <= 1'b1;
                     end
                     default: state_r <= ST_WAIT;
                  endcase
               end else if (avs_read) begin
                  state_r <= ST_LINK;
                  case (avs_address)
                     codec_pkg::HOFS_STATUS: begin
                        ssel_r <= 1'b1;
                        rd_r <= 1'b1;
                        grab_reg_r <= 1'b1;
                     end
                     codec_pkg::HOFS_CAPTURE: crd_r <= 1'b1;
                     codec_pkg::HOFS_IDX_WRITE: begin
                        rdata_r <= {24'h00_0000, last_rd_r};
                        state_r <= ST_WAIT;
                     end
                     codec_pkg::HOFS_PINS: begin
                        rdata_r <= {29'h0000_0000, link.irq_pin, link.cap_request_pin,
                                    link.play_request_pin};
                        state_r <= ST_WAIT;
                     end
                     default: state_r <= ST_WAIT;
                  endcase
               end
            end
            ST_LINK: begin
               rd_r <= 1'b0;
               pwr_r <= 1'b0;
               crd_r <= 1'b0;
               if (crd_r)
                  rdata_r <= {16'h0000, link.cap_data};
               if (high_pend_r) begin
                  idx_r <= codec_pkg::IDX_COUNT_HIGH;
                  wdata_r <= high_byte_r;
                  high_pend_r <= 1'b0;
               end else begin
                  wr_r <= 1'b0;
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (grab_reg_r) begin
                  rdata_r <= {24'h00_0000, link.reg_rdata};
                  last_rd_r <= link.reg_rdata;
               end
               wait_r <= 1'b0;
               state_r <= ST_DONE;
            end
            ST_DONE: begin
               wait_r <= 1'b1;
               ssel_r <= 1'b0;
               state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   assign link.index_select = idx_r;
   assign link.status_sel   = ssel_r;
   assign link.reg_wr       = wr_r;
   assign link.reg_rd       = rd_r;
   assign link.reg_wdata    = wdata_r;
   assign link.play_wr      = pwr_r;
   assign link.play_data    = pdata_r;
   assign link.cap_rd       = crd_r;
   assign avs_readdata      = rdata_r;
   assign avs_waitrequest   = wait_r;
endmodule

// [codec_link_chk.sv]
// Link checker for the codec register bank and host
`timescale 1ns/1ps
module codec_link_chk #(
   parameter logic [3:0] REVISION = codec_pkg::REVISION_DEF
) (
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic [3:0] index_select,
   input wire logic       status_sel,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       play_request_pin,
   input wire logic       cap_request_pin,
   input wire logic       irq_pin
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] pin_r, mix_r, hi_r, lo_r;
   logic       rd;
   // Indexed reads only; status_sel ignores the index
   assign rd = reg_rd && !status_sel;
   // Shadow of writable bytes, reserved bits dropped as stored
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pin_r <= 8'h00;
         mix_r <= 8'h00;
         hi_r <= 8'h00;
         lo_r <= 8'h00;
      end else if (reg_wr && !status_sel) begin
         case (index_select)
            4'ha: pin_r <= reg_wdata & 8'hc2;
            4'hd: mix_r <= reg_wdata & 8'hfd;
            4'he: hi_r <= reg_wdata;
            4'hf: lo_r <= reg_wdata;
            default: ;
         endcase
      end
   end
   a_count_bytes: assert property (
      rd && index_select[3:1] == 3'h7 |=> reg_rdata == $past(index_select[0] ? lo_r : hi_r))
      else $error("base count byte read mismatch");
   a_ctrl_bytes: assert property (
      rd && (index_select == 4'ha || index_select == 4'hd) |=> reg_rdata == $past(index_select[0] ? mix_r : pin_r))
      else $error("control byte read mismatch");
   a_rev_field: assert property (rd && index_select == 4'hc |=> reg_rdata[3:0] == REVISION)
      else $error("revision field mismatch");
   a_req_status: assert property (
      rd && index_select == 4'hb |=> reg_rdata[4] == $past(play_request_pin || cap_request_pin))
      else $error("request status bit mismatch");
   a_low_idx_zero: assert property (rd && index_select < 4'ha |=> reg_rdata == 8'h00)
      else $error("unmapped index read not zero");
   a_gate_low: assert property (!pin_r[1] && !$past(pin_r[1]) |-> !irq_pin)
      else $error("interrupt pin high while gated off");
   a_irq_rise: assert property ($rose(irq_pin) |-> pin_r[1])
      else $error("interrupt pin rose with gate off");
   a_irq_fall: assert property (
      $fell(irq_pin) |-> $past(reg_wr && (status_sel || index_select == 4'ha)))
      else $error("interrupt pin fell without a clear");
   a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data changed without a read");
   c_irq: cover property ($rose(irq_pin));
   c_clear: cover property (reg_wr && status_sel);
   c_count: cover property (rd && index_select == 4'he);
endmodule

// [test_codec_sample_count_status_regs.sv]
// Testbench joining codec register bank and host controller
`timescale 1ns/1ps
module test_codec_sample_count_status_regs;
   localparam logic [3:0] REV = 4'h3; // Arbitrary value
   logic        sys_clk, nrst, avs_read, avs_write, avs_waitrequest, sample_tick;
   logic        playback_on, play_prog_io, calib_run, capture_on, request_block_bit;
   logic [4:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0]  left_level, right_level, ext_ctrl_pins;
   logic [15:0] adc_sample, dac_sample;
   int          failures, checks_done, cyc;
   codec_link_if link ();
   codec_device #(.REVISION(REV)) u_codec_device (.sys_clk(sys_clk), .nrst(nrst), .link(link),
      .sample_tick(sample_tick), .playback_on(playback_on), .capture_on(capture_on), .play_prog_io(play_prog_io),
      .cap_prog_io(1'b0), .request_block_bit(request_block_bit), .mode_change_state(1'b0), .calib_run(calib_run),
      .left_level(left_level), .right_level(right_level), .adc_sample(adc_sample),
      .ext_ctrl_pins(ext_ctrl_pins), .dac_sample(dac_sample));
   codec_host u_codec_host (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link));
   codec_link_chk #(.REVISION(REV)) u_codec_link_chk (.sys_clk(sys_clk), .nrst(nrst),
      .index_select(link.index_select), .status_sel(link.status_sel), .reg_wr(link.reg_wr),
      .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
      .play_request_pin(link.play_request_pin), .cap_request_pin(link.cap_request_pin),
      .irq_pin(link.irq_pin));
   // Free-running 100 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic end_of_test;
      if (failures == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Hang guard; the whole run needs a few hundred cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_of_test;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Avalon access held until waitrequest is sampled low
   task automatic av(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic iwr(input logic [3:0] i, input logic [7:0] d);
      av(1'b1, 5'h00, {20'h0, i, d});
   endtask
   task automatic ird(input logic [3:0] i);
      av(1'b1, 5'h04, {28'h0, i});
      av(1'b0, 5'h00, 32'h0);
   endtask
   task automatic tick;
      @(posedge sys_clk);
      sample_tick <= 1'b1;
      @(posedge sys_clk);
      sample_tick <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic t_regs;
      for (int i = 10; i < 16; i++) begin
         if (i != 12) begin
            ird(i[3:0]);
            chk(q, 32'h0);
         end
      end
      iwr(4'ha, 8'hff);
      chk({30'h0, ext_ctrl_pins}, 32'h3);
      ird(4'ha);
      chk(q, 32'hc2);
      iwr(4'hc, 8'hff);
      ird(4'hc);
      chk(q & 32'hf, {28'h0, REV});
      ird(4'h3);
      chk(q, 32'h0);
      iwr(4'hf, 8'h5a);
      iwr(4'he, 8'ha5);
      ird(4'hf);
      chk(q, 32'h5a);
      ird(4'he);
      chk(q, 32'ha5);
   endtask
   // Mix of live input at three attenuation codes, then muted
   task automatic t_mix;
      adc_sample <= 16'h1000;
      iwr(4'hd, 8'h01);
      tick;
      chk({16'h0, dac_sample}, 32'h1000);
      iwr(4'hd, 8'h11);
      tick;
      chk({16'h0, dac_sample}, 32'h0800);
      iwr(4'hd, 8'h05);
      tick;
      chk({16'h0, dac_sample}, 32'h0d70);
      iwr(4'hd, 8'h00);
      tick;
      chk({16'h0, dac_sample}, 32'h0);
   endtask
   task automatic t_count;
      iwr(4'ha, 8'h02);
      av(1'b1, 5'h14, 32'h2);
      playback_on <= 1'b1;
      play_prog_io <= 1'b1;
      repeat (2) tick;
      av(1'b0, 5'h18, 32'h0);
      chk(q & 32'h4, 32'h0);
      tick;
      av(1'b0, 5'h18, 32'h0);
      chk(q & 32'h4, 32'h4);
      ird(4'hf);
      chk(q, 32'h2);
      av(1'b1, 5'h08, 32'h0);
      av(1'b0, 5'h18, 32'h0);
      chk(q & 32'h4, 32'h0);
      iwr(4'ha, 8'h00);
      repeat (3) tick;
      av(1'b0, 5'h18, 32'h0);
      chk(q & 32'h4, 32'h0);
      av(1'b0, 5'h08, 32'h0);
      chk(q & 32'h1, 32'h1);
      request_block_bit <= 1'b1;
      repeat (3) tick;
      av(1'b1, 5'h08, 32'h0);
      repeat (2) tick;
      av(1'b0, 5'h08, 32'h0);
      chk(q & 32'h1, 32'h0);
      av(1'b1, 5'h08, 32'h0);
   endtask
   // Starved playback, then one sample delivered in time
   task automatic t_under;
      play_prog_io <= 1'b0;
      calib_run <= 1'b1;
      left_level <= 2'h1;
      right_level <= 2'h3;
      tick;
      chk({16'h0, dac_sample}, 32'h0);
      ird(4'hb);
      chk(q, 32'h7d);
      av(1'b0, 5'h08, 32'h0);
      chk(q & 32'h10, 32'h10);
      av(1'b1, 5'h0c, 32'h1234);
      tick;
      chk({16'h0, dac_sample}, 32'h1234);
      ird(4'hb);
      chk(q & 32'h40, 32'h0);
      tick;
      chk({16'h0, dac_sample}, 32'h0);
   endtask
   // Unread capture sample kept, newer one dropped
   task automatic t_cap;
      capture_on <= 1'b1;
      adc_sample <= 16'h0111;
      tick;
      adc_sample <= 16'h0222;
      tick;
      ird(4'hb);
      chk(q & 32'h80, 32'h80);
      av(1'b0, 5'h10, 32'h0);
      chk(q, 32'h0111);
   endtask
   // Reset held 12 cycles, then the scenarios
   initial begin
      {nrst, avs_read, avs_write, sample_tick, playback_on, play_prog_io, calib_run} = 7'h00;
      {avs_address, avs_writedata, left_level, right_level, adc_sample} = 57'h0;
      {capture_on, request_block_bit} = 2'h0;
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      t_regs;
      t_mix;
      t_count;
      t_under;
      t_cap;
      end_of_test;
   end
endmodule
